// ---- design/ift_timer.sv ----
// Interval flag timer top: select, carry flag, chip-enable reset, interrupt
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ift_map.svh"
module ift_timer #(
   parameter int unsigned BASE_CYC = `IFT_BASE_CYC
) (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic [7:0] reg_addr,
   input  wire logic [3:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [3:0] reg_rdata,
   input  wire logic       chip_enable,
   input  wire logic       clock_stop,
   output logic            ce_reset,
   output logic            exec_start,
   output logic            irq
);
   ift_pulse_if pulses ();

   ift_pulse_gen #(.BASE_CYC(BASE_CYC)) u_gen (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .pulses (pulses.gen)
   );

   logic [1:0]       sel_ff;
   logic             carry_ff;
   logic             armed_ff;
   logic             sel_lvl_ff;
   logic [3:0]       rdata_ff;
   logic [1:0]       stat_ff;
   logic [1:0]       mask_ff;
   logic [2:0]       ce_sync_ff;
   logic             ce_lvl_ff;
   logic             ce_rst_ff;
   logic             start_ff;
   logic             booted_ff;
   ift_pkg::ift_ce_e ce_st_ff;
   ift_pkg::ift_ce_e nxt_ce_st;

   // Select bits: hi is bit 1, lo is bit 0
   wire       interval_select_hi = sel_ff[1];
   wire       interval_select_lo = sel_ff[0];

   function automatic logic pick(input logic [3:0] v, input logic hi, input logic lo);
      case ({hi, lo})
         ift_pkg::IFT_SEL_100MS: pick = v[3];
         ift_pkg::IFT_SEL_50MS:  pick = v[2];
         ift_pkg::IFT_SEL_20MS:  pick = v[1];
         ift_pkg::IFT_SEL_10MS:  pick = v[0];
         default:                pick = v[3];
      endcase
   endfunction : pick

   wire sel_lvl  = pick(pulses.level, interval_select_hi, interval_select_lo);
   // Rising edge of whichever pulse is selected now, including a switch from a low pulse
   // onto a high pulse; a switch onto a low pulse leaves the flag alone
   wire sel_rise = sel_lvl & ~sel_lvl_ff;
   wire rise_10  = pulses.rise[3];

   wire hit_carry = (reg_addr == `IFT_CARRY_ADDR);
   wire hit_sel   = (reg_addr == `IFT_SELECT_ADDR);
   wire hit_stat  = (reg_addr == `IFT_IRQ_STAT_ADDR);
   wire hit_mask  = (reg_addr == `IFT_IRQ_MASK_ADDR);
   // The read-clear access is the register read instruction of firmware
   wire register_read_instruction = reg_rd & hit_carry;

   // Chip-enable reset fires on a selected rise unless a flag read collides
   wire ce_fire = (ce_st_ff == ift_pkg::IFT_CE_WAIT) & sel_rise & ~register_read_instruction;
   // Flag sets on rise once armed; chip-enable reset and clock stop force it
   wire set_ev  = (sel_rise & armed_ff) | ce_fire | clock_stop;
   wire interval_carry_flag = carry_ff;

   always_comb begin
      nxt_ce_st = ce_st_ff;
      case (ce_st_ff)
         ift_pkg::IFT_CE_IDLE: if (ce_lvl_ff) nxt_ce_st = ift_pkg::IFT_CE_WAIT;
         ift_pkg::IFT_CE_WAIT: begin
            if (!ce_lvl_ff) nxt_ce_st = ift_pkg::IFT_CE_IDLE;
            else if (ce_fire) nxt_ce_st = ift_pkg::IFT_CE_HOLD;
         end
         ift_pkg::IFT_CE_HOLD: if (!ce_lvl_ff) nxt_ce_st = ift_pkg::IFT_CE_IDLE;
         default: nxt_ce_st = ift_pkg::IFT_CE_IDLE;
      endcase
   end

   // Pin input: three stages, level changes when last two agree
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ce_sync_ff <= 3'h0;
         ce_lvl_ff  <= 1'b0;
      end else begin
         ce_sync_ff <= {ce_sync_ff[1:0], chip_enable};
         if (ce_sync_ff[2] == ce_sync_ff[1]) ce_lvl_ff <= ce_sync_ff[2];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sel_ff     <= `IFT_SEL_RST;
         sel_lvl_ff <= 1'b0;
         ce_st_ff   <= ift_pkg::IFT_CE_IDLE;
      end else begin
         if (reg_wr && hit_sel) sel_ff <= reg_wdata[1:0];
         sel_lvl_ff <= sel_lvl;
         ce_st_ff   <= nxt_ce_st;
      end
   end

   // Power-on reset clears the flag; it stays blocked until first read
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         carry_ff <= 1'b0;
         armed_ff <= 1'b0;
      end else begin
         if (register_read_instruction) armed_ff <= 1'b1;
         // Set wins over the read-clear so no rise is lost
         if (set_ev) carry_ff <= 1'b1;
         else if (register_read_instruction) carry_ff <= 1'b0;
      end
   end

   // Read data valid only in the cycle after the strobe; flag in bit 0
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= 4'h0;
      end else if (reg_rd) begin
         if (hit_carry)     rdata_ff <= {3'h0, interval_carry_flag};
         else if (hit_sel)  rdata_ff <= {2'h0, sel_ff};
         else if (hit_stat) rdata_ff <= {2'h0, stat_ff};
         else if (hit_mask) rdata_ff <= {2'h0, mask_ff};
         else               rdata_ff <= 4'h0;
      end else begin
         rdata_ff <= 4'h0;
      end
   end

   // Interrupt: bit 0 selected rise, bit 1 chip-enable reset; write one clears
   wire [1:0] ev = {ce_fire, sel_rise};
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stat_ff <= 2'h0;
         mask_ff <= 2'h0;
      end else begin
         if (reg_wr && hit_mask) mask_ff <= reg_wdata[1:0];
         stat_ff <= ev | (stat_ff & ~((reg_wr && hit_stat) ? reg_wdata[1:0] : 2'h0));
      end
   end

   // Execution start pulse on 10 Hz rise after power-on or chip-enable reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ce_rst_ff <= 1'b0;
         start_ff  <= 1'b0;
         booted_ff <= 1'b0;
      end else begin
         ce_rst_ff <= ce_fire;
         start_ff  <= 1'b0;
         if (ce_fire) begin
            booted_ff <= 1'b0;
         end else if (rise_10 && !booted_ff) begin
            booted_ff <= 1'b1;
            start_ff  <= 1'b1;
         end
      end
   end

   assign reg_rdata  = rdata_ff;
   assign ce_reset   = ce_rst_ff;
   assign exec_start = start_ff;
   assign irq        = |(stat_ff & mask_ff);
endmodule : ift_timer
`default_nettype wire

// ---- design/ift_map.svh ----
// Constants for the interval flag timer
// Behaviour
// - Four selectable set rates: 10, 20, 50 and 100 Hz; 00 selects 100 ms.
// - All four pulses run continuously with fixed phase offsets; selection never restarts.
// - Select change: new pulse falling keeps flag; new pulse rising sets flag.
// - Reading the carry flag returns its value and clears it.
// - After power-on the flag is 0 and blocked until first read.
// - Chip enable high: reset applied at next selected pulse rise, flag set.
// - Program start is released on 10 Hz rise after power-on and chip-enable reset.
// - Flag 0 after power-on reset, 1 after chip-enable reset.
// - A read coinciding with pending chip-enable reset wins; reset waits one more rise.
// - Clock stop instruction sets the flag, as chip-enable reset does.
// - Flag is bit 0 of read-clear register 17H; other bits read 0.
// - Pulses are divided down from the system clock.
`ifndef IFT_MAP_SVH
`define IFT_MAP_SVH
`define IFT_CLK_HZ        50000000
`define IFT_BASE_US       5000
`define IFT_BASE_CYC      ((`IFT_CLK_HZ / 1000000) * `IFT_BASE_US)
`define IFT_PHASE_CNT     20
`define IFT_CARRY_ADDR    8'h17
`define IFT_SELECT_ADDR   8'h10
`define IFT_IRQ_STAT_ADDR 8'h11
`define IFT_IRQ_MASK_ADDR 8'h12
`define IFT_SEL_RST       2'h0
`define IFT_PH_100HZ      5'h00
`define IFT_PH_50HZ       5'h01
`define IFT_PH_20HZ       5'h02
`define IFT_PH_10HZ       5'h03
`define IFT_HALF_100HZ    5'h01
`define IFT_HALF_50HZ     5'h02
`define IFT_HALF_20HZ     5'h05
`define IFT_HALF_10HZ     5'h0A
`endif

// ---- design/ift_pkg.sv ----
// Types for the interval flag timer
package ift_pkg;
   typedef enum logic [1:0] {
      IFT_SEL_100MS = 2'b00,
      IFT_SEL_50MS  = 2'b01,
      IFT_SEL_20MS  = 2'b10,
      IFT_SEL_10MS  = 2'b11
   } ift_sel_e;
   typedef enum logic [1:0] {
      IFT_CE_IDLE = 2'b00,
      IFT_CE_WAIT = 2'b01,
      IFT_CE_HOLD = 2'b10
   } ift_ce_e;
endpackage : ift_pkg

// ---- design/ift_pulse_if.sv ----
// Bundle of the four running set pulses
`timescale 1ns/1ps
`default_nettype none
interface ift_pulse_if;
   logic [3:0] level;
   logic [3:0] rise;
   modport gen (output level, output rise);
   modport use_p (input level, input rise);
endinterface : ift_pulse_if
`default_nettype wire

// ---- design/ift_pulse_gen.sv ----
// Divider producing four free-running square pulses
`timescale 1ns/1ps
`default_nettype none
`include "ift_map.svh"
module ift_pulse_gen #(
   parameter int unsigned BASE_CYC = `IFT_BASE_CYC
) (
   input  wire logic    mclk,
   input  wire logic    rst_n,
   ift_pulse_if.gen     pulses
);
   logic [31:0] base_cnt_ff;
   logic [4:0]  ph_ff;
   logic [3:0]  lvl_ff;
   logic [3:0]  nxt_lvl;
   wire         base_tick = (base_cnt_ff == BASE_CYC - 1);
   wire  [4:0]  nxt_ph    = (ph_ff == 5'(`IFT_PHASE_CNT - 1)) ? 5'h00 : ph_ff + 5'h01;

   // Half periods in 5 ms steps: 100 Hz 1, 50 Hz 2, 20 Hz 5, 10 Hz 10
   function automatic logic sq(input logic [4:0] p, input logic [4:0] half,
                               input logic [4:0] off);
      logic [5:0] s;
      s = 6'(p) + 6'(off);
      if (s >= 6'(`IFT_PHASE_CNT)) s = s - 6'(`IFT_PHASE_CNT);
      sq = ((s / 6'(half)) % 6'h02) == 6'h00;
   endfunction : sq

   // Fixed phase offsets keep 10 Hz and 50 Hz rises apart from those of the other rates
   assign nxt_lvl[0] = sq(nxt_ph, `IFT_HALF_100HZ, `IFT_PH_100HZ);
   assign nxt_lvl[1] = sq(nxt_ph, `IFT_HALF_50HZ, `IFT_PH_50HZ);
   assign nxt_lvl[2] = sq(nxt_ph, `IFT_HALF_20HZ, `IFT_PH_20HZ);
   assign nxt_lvl[3] = sq(nxt_ph, `IFT_HALF_10HZ, `IFT_PH_10HZ);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         base_cnt_ff <= 32'h0;
         ph_ff       <= 5'h00;
         lvl_ff      <= 4'h0;
      end else if (base_tick) begin
         base_cnt_ff <= 32'h0;
         ph_ff       <= nxt_ph;
         lvl_ff      <= nxt_lvl;
      end else begin
         base_cnt_ff <= base_cnt_ff + 32'h1;
      end
   end

   assign pulses.level = lvl_ff;
   assign pulses.rise  = base_tick ? (nxt_lvl & ~lvl_ff) : 4'h0;
endmodule : ift_pulse_gen
`default_nettype wire

// ---- tb/ift_timer_properties.sv ----
// Port-level checks of the interval flag timer
`timescale 1ns/1ps
`default_nettype none
module ift_timer_chk #(
   parameter int unsigned BASE_CYC = 10
) (
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [3:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [3:0] reg_rdata,
   input wire logic       chip_enable,
   input wire logic       clock_stop,
   input wire logic       ce_reset,
   input wire logic       exec_start,
   input wire logic       irq
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   sequence s_rd_carry;
      reg_rd && reg_addr == 8'h17;
   endsequence
   sequence s_rd_other;
      reg_rd && !(reg_addr inside {8'h10, 8'h11, 8'h12, 8'h17});
   endsequence
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 4'h0)
      else $error("read data outside a read");
   a_carry_upper: assert property (s_rd_carry |=> reg_rdata[3:1] == 3'h0)
      else $error("carry register upper bits set");
   a_unmapped_zero: assert property (s_rd_other |=> reg_rdata == 4'h0)
      else $error("unmapped read not zero");
   a_ce_single: assert property (ce_reset |=> !ce_reset [*8])
      else $error("chip-enable reset pulse too long");
   a_exec_single: assert property (exec_start |=> !exec_start [*8])
      else $error("program start pulse too long");
   a_stop_sets: assert property (clock_stop ##[1:4] s_rd_carry |=> reg_rdata[0])
      else $error("clock stop left carry clear");
   a_ce_sets: assert property (ce_reset ##[1:4] s_rd_carry |=> reg_rdata[0])
      else $error("chip-enable reset left carry clear");
   a_mask_quiet: assert property (reg_wr && reg_addr == 8'h12 && reg_wdata == 4'h0 |=> !irq)
      else $error("irq high with all masked");
endmodule : ift_timer_chk
bind ift_timer ift_timer_chk #(.BASE_CYC(BASE_CYC)) chk_u (.mclk, .rst_n, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .chip_enable, .clock_stop, .ce_reset,
   .exec_start, .irq);
`default_nettype wire

// ---- tb/ift_fw_model.sv ----
// Polling firmware model, also the register bus master
`timescale 1ns/1ps
`default_nettype none
module ift_fw_model #(
   parameter int POLL = 7
) (
   input  wire logic       mclk,
   input  wire logic       poll_en,
   input  wire logic [3:0] reg_rdata,
   output var logic  [7:0] reg_addr,
   output var logic  [3:0] reg_wdata,
   output var logic        reg_wr,
   output var logic        reg_rd,
   output var int          sets
);
   logic [3:0] d;
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 4'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      sets = 0;
   end
   task automatic wr(input logic [7:0] a, input logic [3:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [3:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      v = reg_rdata;
   endtask : rd
   // Reads on every cycle on purpose: such a loop always meets the set edge
   task automatic rd_run(input int n);
      @(posedge mclk);
      reg_addr <= 8'h17;
      reg_rd <= 1'b1;
      repeat (n) @(posedge mclk);
      reg_rd <= 1'b0;
   endtask : rd_run
   // Period shorter than any interval and dividing none, so no set is missed
   // and a set can never stay aligned with a read to hold off chip-enable reset
   always begin
      @(posedge mclk);
      if (poll_en) begin
         rd(8'h17, d);
         if (d[0] === 1'b1) sets++;
         repeat (POLL - 3) @(posedge mclk);
      end
   end
endmodule : ift_fw_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the interval flag timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int B = 10;
   logic       mclk;
   logic       rst_n;
   logic       chip_enable;
   logic       clock_stop;
   logic       poll_en;
   logic [7:0] reg_addr;
   logic [3:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [3:0] reg_rdata;
   logic       ce_reset;
   logic       exec_start;
   logic       irq;
   logic [3:0] d;
   int         err_total;
   int         check_count;
   int         n_exec;
   int         sets;
   int         n_ce;
   ift_timer #(.BASE_CYC(B)) dut_u (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .chip_enable, .clock_stop, .ce_reset, .exec_start, .irq);
   ift_fw_model fw_u (.mclk, .poll_en, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .sets);
   task automatic chk4(input logic [3:0] g, input logic [3:0] e);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask : chk4
   task automatic chkn(input int g, input int lo, input int hi);
      check_count++;
      if (g < lo || g > hi) begin
         err_total++;
         $display("[ERR] %0t count %0d", $time, g);
      end
   endtask : chkn
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test
   // Polls every two cycles, so the gap between two sets is measured exactly
   task automatic wait_set(output int t);
      d = 4'h0;
      for (int i = 0; i < 300 && d[0] !== 1'b1; i++) fw_u.rd(8'h17, d);
      t = int'($time / 20);
      chk4(d, 4'h1);
   endtask : wait_set
   task automatic t_por;
      repeat (25 * B) @(posedge mclk);
      chkn(n_exec, 1, 1);
      fw_u.rd(8'h17, d);
      chk4(d, 4'h0);
      repeat (25 * B) @(posedge mclk);
      fw_u.rd(8'h17, d);
      chk4(d, 4'h1);
      fw_u.rd(8'h17, d);
      chk4(d, 4'h0);
      $display("t_por done");
   endtask : t_por
   task automatic t_sel;
      int t0;
      int t1;
      int per[4] = '{20, 10, 4, 2};
      for (int s = 0; s < 4; s++) begin
         fw_u.wr(8'h10, 4'(s));
         wait_set(t0);
         wait_set(t0);
         wait_set(t1);
         chkn(t1 - t0, per[s] * B, per[s] * B);
      end
      $display("t_sel done");
   endtask : t_sel
   // Right after a 10 Hz rise the 100 Hz pulse is low for one phase step
   task automatic t_r3;
      int t;
      fw_u.wr(8'h10, 4'h0);
      wait_set(t);
      wait_set(t);
      fw_u.wr(8'h10, 4'h3);
      fw_u.rd(8'h17, d);
      chk4(d, 4'h0);
      fw_u.wr(8'h10, 4'h0);
      fw_u.rd(8'h17, d);
      chk4(d, 4'h1);
      fw_u.wr(8'h10, 4'h3);
      $display("t_r3 done");
   endtask : t_r3
   // A read on every cycle collides with each rise and holds the reset off
   task automatic t_r9;
      int i;
      repeat (10) @(posedge mclk);
      n_ce = 0;
      chip_enable <= 1'b1;
      fw_u.rd_run(80);
      chkn(n_ce, 0, 0);
      for (i = 0; i < 60 && ce_reset !== 1'b1; i++) @(negedge mclk);
      chk4({3'h0, ce_reset}, 4'h1);
      @(posedge mclk);
      chip_enable <= 1'b0;
      $display("t_r9 done");
   endtask : t_r9
   task automatic t_ce;
      int i;
      n_exec = 0;
      @(posedge mclk);
      chip_enable <= 1'b1;
      for (i = 0; i < 60 && ce_reset !== 1'b1; i++) @(negedge mclk);
      chk4({3'h0, ce_reset}, 4'h1);
      fw_u.rd(8'h17, d);
      chk4(d, 4'h1);
      repeat (22 * B) @(posedge mclk);
      chip_enable <= 1'b0;
      chkn(n_exec, 1, 1);
      $display("t_ce done");
   endtask : t_ce
   // Aligned just after a rise, so only the stop can set the flag here
   task automatic t_stop;
      int t;
      wait_set(t);
      wait_set(t);
      fw_u.rd(8'h17, d);
      chk4(d, 4'h0);
      @(posedge mclk);
      clock_stop <= 1'b1;
      @(posedge mclk);
      clock_stop <= 1'b0;
      fw_u.rd(8'h17, d);
      chk4(d, 4'h1);
      $display("t_stop done");
   endtask : t_stop
   task automatic t_irq;
      int t;
      fw_u.wr(8'h12, 4'h0);
      fw_u.wr(8'h11, 4'h3);
      fw_u.wr(8'h12, 4'h1);
      for (int i = 0; i < 40 && irq !== 1'b1; i++) @(negedge mclk);
      chk4({3'h0, irq}, 4'h1);
      fw_u.rd(8'h11, d);
      chk4(d, 4'h1);
      // Clear just after a rise so no new event refills the status bit
      wait_set(t);
      fw_u.wr(8'h11, 4'h1);
      @(negedge mclk);
      chk4({3'h0, irq}, 4'h0);
      fw_u.wr(8'h12, 4'h0);
      fw_u.rd(8'h3F, d);
      chk4(d, 4'h0);
      $display("t_irq done");
   endtask : t_irq
   task automatic t_poll;
      int n;
      n = sets;
      @(posedge mclk);
      poll_en <= 1'b1;
      repeat (20 * B) @(posedge mclk);
      poll_en <= 1'b0;
      repeat (10) @(posedge mclk);
      chkn(sets - n, 9, 11);
      $display("t_poll done");
   endtask : t_poll
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   always @(negedge mclk) if (exec_start === 1'b1) n_exec++;
   always @(negedge mclk) if (ce_reset === 1'b1) n_ce++;
   initial begin
      #160000;
      err_total++;
      stop_test();
   end
   initial begin
      rst_n = 1'b0;
      chip_enable = 1'b0;
      clock_stop = 1'b0;
      poll_en = 1'b0;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      t_por();
      t_sel();
      t_r3();
      t_ce();
      t_r9();
      t_stop();
      t_irq();
      t_poll();
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
